// ---- src/jnp_dev.sv ----
// Device end: test access port with reset hold, unlock, command and byte registers
// How it works
// - Programmer uses only the four port pins
// - Port works when fuse set, disable clear
// - Reset low clears disable bit, two clocks
// - Programmer avoids reset trick for scan/debug
// - Programmer keeps test clock below chip max
// - All shift registers move LSB first
// - Four-bit instruction selects one data register
// - Run-Test/Idle generates internal execute clocks
// - Code 0xC selects one-bit reset hold
// - Hold bit one resets chip immediately
// - Reset lingers a time-out after release
// - Programmer resets chip before unlocking
// - Code 0x4 shifts unlock, compares at update
// - Only exact key enables programming
// - Unlock cleared at power-on; programmer clears too
// - Code 0x5 captures result, shifts new command
// - Update applies command; first idle clock after it executes
// - Code 0x6 shifts low command byte
// - Fill update copies byte, writes within 11
// - Fill alternates low/high, pre-increments address
// - Code 0x7 captures low then high byte
// - Fetch post-increments after each high byte
`default_nettype none
module jnp_dev #(
	parameter int TIMEOUT_CYC = jnp_pkg::RESET_TIMEOUT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	jnp_if.dev port,
	input wire logic i_port_enable_fuse,
	input wire logic i_set_disable,
	input wire logic i_ext_reset_n,
	input wire logic [14:0] i_cmd_result,
	input wire logic [15:0] i_mem_word,
	output logic o_core_reset,
	output logic o_scan_port_disable_bit,
	output logic o_prog_mode,
	output logic [14:0] o_cmd,
	output logic o_cmd_exec,
	output logic [7:0] o_fill_data,
	output logic o_fill_write,
	output logic o_fill_high,
	output logic o_addr_inc,
	output logic o_tdo,
	output logic o_tdo_oe
);
	// ------------------------------------------------------------
	// Pin synchronisers and test-clock edge detection
	// ------------------------------------------------------------
	logic [1:0] tck_sync_reg, tms_sync_reg, tdi_sync_reg, rst_sync_reg;
	logic tck_prev_reg;
	logic tck_rise, tck_fall, port_live;
	// Two flops on every pin; only the second flop feeds logic
	always_ff @(posedge i_clk) begin
		tck_sync_reg <= {tck_sync_reg[0], port.tck};
		tms_sync_reg <= {tms_sync_reg[0], port.tms};
		tdi_sync_reg <= {tdi_sync_reg[0], port.tdi};
		rst_sync_reg <= {rst_sync_reg[0], i_ext_reset_n};
		tck_prev_reg <= tck_sync_reg[1];
	end
	assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
	assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;

	// ------------------------------------------------------------
	// Port disable bit and external reset
	// ------------------------------------------------------------
	logic [1:0] low_cnt_reg;
	logic dis_reg;
	// Reset held low for two chip clocks frees the port pins
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			dis_reg <= 1'b0;
			low_cnt_reg <= 2'h0;
		end else begin
			if (rst_sync_reg[1])
				low_cnt_reg <= 2'h0;
			else if (low_cnt_reg != 2'(jnp_pkg::DISABLE_CLEAR_CYC))
				low_cnt_reg <= low_cnt_reg + 2'h1;
			// A set in the same cycle as the clear wins
			if (i_set_disable)
				dis_reg <= 1'b1;
			else if (!rst_sync_reg[1] && low_cnt_reg == 2'(jnp_pkg::DISABLE_CLEAR_CYC - 1))
				dis_reg <= 1'b0;
		end
	end
	assign port_live = i_port_enable_fuse & ~dis_reg;

	// ------------------------------------------------------------
	// TAP controller and instruction register
	// ------------------------------------------------------------
	jnp_pkg::jnp_tap_t tap_reg;
	logic [3:0] ir_sh_reg, ir_reg;
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !port_live)
			tap_reg <= jnp_pkg::TAP_RESET;
		else if (tck_rise)
			tap_reg <= jnp_pkg::jnp_tap_step(tap_reg, tms_sync_reg[1]);
	end
	// Four-bit instruction, LSB shifted first
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !port_live) begin
			ir_sh_reg <= 4'h0;
			ir_reg <= jnp_pkg::IR_BYPASS;
		end else if (tck_rise) begin
			case (tap_reg)
				jnp_pkg::TAP_RESET: ir_reg <= jnp_pkg::IR_BYPASS;
				jnp_pkg::TAP_CAP_IR: ir_sh_reg <= 4'h1;
				jnp_pkg::TAP_SHIFT_IR: ir_sh_reg <= {tdi_sync_reg[1], ir_sh_reg[3:1]};
				jnp_pkg::TAP_UPD_IR: ir_reg <= ir_sh_reg;
				default: ir_reg <= ir_reg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data registers
	// ------------------------------------------------------------
	logic hold_reg, bypass_reg, first_reg, high_reg, prog_reg;
	logic [15:0] key_reg;
	logic [14:0] cmd_sh_reg, cmd_reg;
	logic [7:0] temp_reg;
	logic [3:0] fill_cnt_reg;
	logic shift_now, cap_now, upd_now;
	logic [3:0] prev_ir_reg;
	assign shift_now = tck_rise && tap_reg == jnp_pkg::TAP_SHIFT_DR;
	assign cap_now = tck_rise && tap_reg == jnp_pkg::TAP_CAP_DR;
	assign upd_now = tck_rise && tap_reg == jnp_pkg::TAP_UPD_DR;
	// Reset hold bit (0xC): TAP itself is not reset by it
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			hold_reg <= 1'b0;
		else if (shift_now && ir_reg == jnp_pkg::IR_RESET_HOLD)
			hold_reg <= tdi_sync_reg[1];
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			bypass_reg <= 1'b0;
		else if (shift_now)
			bypass_reg <= tdi_sync_reg[1];
	end
	// Unlock register: cleared at power-on, compared on update
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			key_reg <= jnp_pkg::UNLOCK_RESET;
			prog_reg <= 1'b0;
		end else if (ir_reg == jnp_pkg::IR_UNLOCK) begin
			if (shift_now)
				key_reg <= {tdi_sync_reg[1], key_reg[15:1]};
			if (upd_now)
				prog_reg <= (key_reg == jnp_pkg::UNLOCK_KEY);
		end
	end
	// Command register; the byte views share its low eight bits
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cmd_sh_reg <= jnp_pkg::CMD_RESET;
			cmd_reg <= jnp_pkg::CMD_RESET;
		end else if (ir_reg == jnp_pkg::IR_COMMAND) begin
			if (cap_now)
				cmd_sh_reg <= i_cmd_result;
			else if (shift_now)
				cmd_sh_reg <= {tdi_sync_reg[1], cmd_sh_reg[14:1]};
			else if (upd_now && prog_reg)
				cmd_reg <= cmd_sh_reg;
		end else if (ir_reg == jnp_pkg::IR_FILL || ir_reg == jnp_pkg::IR_FETCH) begin
			if (cap_now && ir_reg == jnp_pkg::IR_FETCH)
				cmd_sh_reg[7:0] <= high_reg ? i_mem_word[15:8] : i_mem_word[7:0];
			else if (shift_now)
				cmd_sh_reg[7:0] <= {tdi_sync_reg[1], cmd_sh_reg[7:1]};
		end
	end
	// Byte alternation and word address stepping for fill and fetch
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			prev_ir_reg <= jnp_pkg::IR_BYPASS;
			first_reg <= 1'b1;
			high_reg <= 1'b0;
			temp_reg <= 8'h00;
			fill_cnt_reg <= 4'h0;
			o_fill_write <= 1'b0;
			o_fill_high <= 1'b0;
			o_addr_inc <= 1'b0;
		end else begin
			prev_ir_reg <= ir_reg;
			o_fill_write <= 1'b0;
			o_addr_inc <= 1'b0;
			if (ir_reg != prev_ir_reg) begin
				first_reg <= 1'b1;
				high_reg <= 1'b0;
			end else if (prog_reg && ir_reg == jnp_pkg::IR_FILL && upd_now) begin
				temp_reg <= cmd_sh_reg[7:0];
				fill_cnt_reg <= 4'h1;
				o_addr_inc <= ~high_reg & ~first_reg;
				o_fill_high <= high_reg;
				high_reg <= ~high_reg;
				first_reg <= 1'b0;
			end else if (prog_reg && ir_reg == jnp_pkg::IR_FETCH && cap_now) begin
				o_addr_inc <= high_reg;
				high_reg <= ~high_reg;
			end
			// Write lands two test clocks after update, inside the limit
			if (fill_cnt_reg != 4'h0 && tck_rise) begin
				if (fill_cnt_reg == 4'h2) begin
					o_fill_write <= 1'b1;
					fill_cnt_reg <= 4'h0;
				end else begin
					fill_cnt_reg <= fill_cnt_reg + 4'h1;
				end
			end
		end
	end
	assign o_fill_data = temp_reg;
	assign o_cmd = cmd_reg;
	assign o_prog_mode = prog_reg;
	assign o_scan_port_disable_bit = dis_reg;

	// ------------------------------------------------------------
	// Execute pulse and core reset
	// ------------------------------------------------------------
	logic [15:0] tmo_reg;
	logic exec_due_reg;
	// One execute pulse on the first idle clock after a command update, so a
	// visit that only passes through idle cannot run the same command twice
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_cmd_exec <= 1'b0;
			exec_due_reg <= 1'b0;
		end else begin
			o_cmd_exec <= exec_due_reg && prog_reg && tck_rise && tap_reg == jnp_pkg::TAP_IDLE
				&& ir_reg == jnp_pkg::IR_COMMAND;
			if (upd_now && prog_reg && ir_reg == jnp_pkg::IR_COMMAND)
				exec_due_reg <= 1'b1;
			else if (tck_rise && tap_reg == jnp_pkg::TAP_IDLE)
				exec_due_reg <= 1'b0;
		end
	end
	// Hold bit acts at once; time-out runs after release
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tmo_reg <= 16'(TIMEOUT_CYC); // Power-on release waits the time-out too
			o_core_reset <= 1'b1;
		end else begin
			if (hold_reg || !rst_sync_reg[1])
				tmo_reg <= 16'(TIMEOUT_CYC);
			else if (tmo_reg != 16'h0000)
				tmo_reg <= tmo_reg - 16'h0001;
			o_core_reset <= hold_reg || !rst_sync_reg[1] || tmo_reg != 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Test data out, changed on the falling test clock
	// ------------------------------------------------------------
	logic tdo_bit;
	always_comb begin
		case (ir_reg)
			jnp_pkg::IR_RESET_HOLD: tdo_bit = hold_reg;
			jnp_pkg::IR_UNLOCK: tdo_bit = key_reg[0];
			jnp_pkg::IR_COMMAND, jnp_pkg::IR_FILL, jnp_pkg::IR_FETCH: tdo_bit = cmd_sh_reg[0];
			default: tdo_bit = bypass_reg;
		endcase
		if (tap_reg == jnp_pkg::TAP_SHIFT_IR)
			tdo_bit = ir_sh_reg[0];
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_tdo <= 1'b0;
			o_tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			o_tdo <= tdo_bit;
			o_tdo_oe <= tap_reg == jnp_pkg::TAP_SHIFT_DR || tap_reg == jnp_pkg::TAP_SHIFT_IR;
		end
	end
	assign port.tdo = o_tdo;
	assign port.tdo_oe = o_tdo_oe;
endmodule // jnp_dev
`default_nettype wire

// ---- src/jnp_pkg.sv ----
// Package: shared constants and types of the scan-port NVM programming link
`default_nettype none
package jnp_pkg;
	localparam int IR_W = 4;
	localparam int CMD_W = 15;
	localparam int KEY_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [3:0] IR_RESET_HOLD = 4'hc;
	localparam logic [3:0] IR_UNLOCK = 4'h4;
	localparam logic [3:0] IR_COMMAND = 4'h5;
	localparam logic [3:0] IR_FILL = 4'h6;
	localparam logic [3:0] IR_FETCH = 4'h7;
	localparam logic [3:0] IR_BYPASS = 4'hf;
	localparam logic [15:0] UNLOCK_KEY = 16'ha370;
	localparam logic [15:0] UNLOCK_RESET = 16'h0000;
	localparam logic [14:0] CMD_RESET = 15'h0000;
	// Chip clocks from reset low to disable bit cleared
	localparam int DISABLE_CLEAR_CYC = 2;
	// Page-fill write must land within this many test clocks
	localparam int FILL_LIMIT_TCK = 11;
	// Default reset time-out after hold release, chip clocks
	localparam int RESET_TIMEOUT_CYC = 64;
	// Link clock half period in chip clocks (length of each phase)
	localparam int TCK_HALF_CYC = 4;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
		TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} jnp_tap_t;
	// Next TAP state for a given TMS level
	function automatic jnp_tap_t jnp_tap_step(input jnp_tap_t s, input logic tms);
		case (s)
			TAP_RESET: jnp_tap_step = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: jnp_tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: jnp_tap_step = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: jnp_tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: jnp_tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: jnp_tap_step = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: jnp_tap_step = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: jnp_tap_step = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: jnp_tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: jnp_tap_step = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: jnp_tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: jnp_tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: jnp_tap_step = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: jnp_tap_step = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: jnp_tap_step = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: jnp_tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
			default: jnp_tap_step = TAP_RESET;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- src/jnp_if.sv ----
// Interface: the four test-port pins between programmer and device
`default_nettype none
interface jnp_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport prog (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface
`default_nettype wire

// ---- src/jnp_prog.sv ----
// Programmer end: drives the test pins to shift instructions and data
`default_nettype none
module jnp_prog #(
	parameter int HALF_CYC = jnp_pkg::TCK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	jnp_if.prog port,
	input wire logic i_start,
	input wire logic i_is_ir,
	input wire logic [15:0] i_data,
	input wire logic [4:0] i_len,
	input wire logic i_end_idle,
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_rdata
);
	typedef enum logic [2:0] {PG_IDLE, PG_SEL, PG_CAP, PG_SHIFT, PG_EXIT, PG_UPD, PG_RUN} jnp_pst_t;
	jnp_pst_t st_reg;
	logic [1:0] tdo_sync_reg;
	logic [7:0] div_reg;
	logic tck_reg, tms_reg, tdi_reg, ir_reg, sel2_reg, pre_reg;
	logic [15:0] sh_reg;
	logic [4:0] cnt_reg;
	// Test data out is a pin: two flops before use
	always_ff @(posedge i_clk) begin
		tdo_sync_reg <= {tdo_sync_reg[0], port.tdo};
	end
	// Clock divider; the test clock is derived, only pins are used
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			div_reg <= 8'h00;
			tck_reg <= 1'b0;
		end else if (st_reg == PG_IDLE) begin
			div_reg <= 8'h00;
			tck_reg <= 1'b0;
		end else if (div_reg == 8'(HALF_CYC - 1)) begin
			div_reg <= 8'h00;
			tck_reg <= ~tck_reg;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	logic fall;
	assign fall = tck_reg && div_reg == 8'(HALF_CYC - 1);
	// Walk the TAP from idle through one scan; changes on falling edges
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_reg <= PG_IDLE;
			tms_reg <= 1'b0;
			tdi_reg <= 1'b0;
			sh_reg <= 16'h0000;
			cnt_reg <= 5'h00;
			ir_reg <= 1'b0;
			sel2_reg <= 1'b0;
			pre_reg <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			case (st_reg)
				// A first clock with mode select low brings a reset TAP to idle and keeps an idle one there
				PG_IDLE: if (i_start) begin
					st_reg <= PG_SEL;
					sh_reg <= i_data;
					cnt_reg <= i_len;
					ir_reg <= i_is_ir;
					sel2_reg <= 1'b0;
					pre_reg <= 1'b1;
					tms_reg <= 1'b0;
				end
				PG_SEL: if (fall) begin
					if (pre_reg) begin
						pre_reg <= 1'b0;
						tms_reg <= 1'b1;
					end else if (ir_reg && !sel2_reg) begin
						sel2_reg <= 1'b1;
					end else begin
						tms_reg <= 1'b0;
						sel2_reg <= 1'b0;
						st_reg <= PG_CAP;
					end
				end
				// Capture takes one whole clock; the first bit goes out once the shift state is reached
				PG_CAP: if (fall) begin
					if (!sel2_reg) begin
						sel2_reg <= 1'b1;
					end else begin
						st_reg <= PG_SHIFT;
						tdi_reg <= sh_reg[0];
						tms_reg <= cnt_reg == 5'h01;
					end
				end
				// Mode select stays high over the last shift and the exit clock
				PG_SHIFT: if (fall) begin
					sh_reg <= {tdo_sync_reg[1], sh_reg[15:1]};
					cnt_reg <= cnt_reg - 5'h01;
					tdi_reg <= sh_reg[1];
					tms_reg <= (cnt_reg == 5'h02) || (cnt_reg == 5'h01);
					if (cnt_reg == 5'h01)
						st_reg <= PG_EXIT;
				end
				PG_EXIT: if (fall) begin
					tms_reg <= 1'b0;
					st_reg <= PG_UPD;
					o_rdata <= sh_reg >> (5'h10 - i_len);
				end
				PG_UPD: if (fall) begin
					tms_reg <= 1'b0;
					st_reg <= i_end_idle ? PG_RUN : PG_IDLE;
					o_done <= !i_end_idle;
				end
				PG_RUN: if (fall) begin
					st_reg <= PG_IDLE;
					o_done <= 1'b1;
				end
				default: st_reg <= PG_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			o_busy <= 1'b0;
		else
			o_busy <= st_reg != PG_IDLE || i_start;
	end
	assign port.tck = tck_reg;
	assign port.tms = tms_reg;
	assign port.tdi = tdi_reg;
endmodule // jnp_prog
`default_nettype wire

// ---- sim/jnp_chk.sv ----
// Checker: concurrent checks on the scan-port link pins and the device end's outputs
`default_nettype none
module jnp_chk (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_ext_reset_n,
	input wire logic i_core_reset,
	input wire logic i_disable_bit,
	input wire logic i_prog_mode,
	input wire logic i_cmd_exec,
	input wire logic i_fill_write,
	input wire logic i_addr_inc
);
	// ----------------------------------------
	// Clocking and step sequences
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// One link clock period is eight chip clocks, so no execute pulse can repeat sooner
	sequence s_exec_once;
		i_cmd_exec ##1 !i_cmd_exec [*7];
	endsequence
	sequence s_reset_linger;
		i_core_reset [*8];
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_tck_high_half: assert property ($rose(i_tck) |-> i_tck [*4])
		else $error("link clock high phase shorter than four clocks");
	a_tck_low_half: assert property ($fell(i_tck) |-> !i_tck [*4])
		else $error("link clock low phase shorter than four clocks");
	a_mode_on_low: assert property ($changed(i_tms) |-> !i_tck)
		else $error("mode select moved while link clock high");
	a_exec_unlocked: assert property (i_cmd_exec |-> i_prog_mode)
		else $error("command executed while locked");
	a_exec_per_idle: assert property (i_cmd_exec |-> s_exec_once)
		else $error("more than one execute pulse per idle clock");
	a_fill_unlocked: assert property (i_fill_write |-> i_prog_mode ##1 !i_fill_write)
		else $error("page fill write while locked or too long");
	a_inc_pulse: assert property (i_addr_inc |=> !i_addr_inc)
		else $error("address increment longer than one clock");
	a_por_locked: assert property ($rose(i_rstn) |-> !i_prog_mode)
		else $error("programming unlocked after power-on");
	a_por_linger: assert property ($rose(i_rstn) |-> s_reset_linger)
		else $error("core reset time-out cut short");
	a_disable_clear: assert property (!i_ext_reset_n [*6] |-> !i_disable_bit)
		else $error("disable bit kept under external reset");
endmodule // jnp_chk
`default_nettype wire

// ---- sim/tb_jtag_nvm_programming_port.sv ----
// Testbench: programmer end and device end joined, driven through scan requests
`default_nettype none
module tb_jtag_nvm_programming_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_start = 1'b0;
	logic i_is_ir = 1'b0;
	logic [15:0] i_data = 16'h0000;
	logic [4:0] i_len = 5'h01;
	logic i_end_idle = 1'b0;
	logic i_fuse = 1'b1;
	logic i_set_disable = 1'b0;
	logic i_ext_reset_n = 1'b1;
	logic [14:0] i_cmd_result = 15'h0000;
	logic [15:0] i_mem_word = 16'h0000;
	logic o_busy, o_done, o_core_reset, o_dis, o_prog_mode, o_cmd_exec, o_fill_write, o_fill_high, o_addr_inc;
	logic [15:0] o_rdata;
	logic [14:0] o_cmd;
	logic [7:0] o_fill_data;
	logic [15:0] rd;
	logic [8:0] fill_q[$];
	logic [7:0] fb[3] = '{8'h3c, 8'hc3, 8'h5a};
	int n_fail = 0;
	int samples_checked = 0;
	int n_exec = 0;
	int n_inc = 0;
	int e;
	jnp_if port_if();
	jnp_prog jnp_prog_inst (.i_clk(i_clk), .i_rstn(i_rstn), .port(port_if.prog), .i_start(i_start),
		.i_is_ir(i_is_ir), .i_data(i_data), .i_len(i_len), .i_end_idle(i_end_idle), .o_busy(o_busy),
		.o_done(o_done), .o_rdata(o_rdata));
	jnp_dev #(.TIMEOUT_CYC(8)) jnp_dev_inst (.i_clk(i_clk), .i_rstn(i_rstn), .port(port_if.dev),
		.i_port_enable_fuse(i_fuse), .i_set_disable(i_set_disable), .i_ext_reset_n(i_ext_reset_n),
		.i_cmd_result(i_cmd_result), .i_mem_word(i_mem_word), .o_core_reset(o_core_reset),
		.o_scan_port_disable_bit(o_dis), .o_prog_mode(o_prog_mode), .o_cmd(o_cmd), .o_cmd_exec(o_cmd_exec),
		.o_fill_data(o_fill_data), .o_fill_write(o_fill_write), .o_fill_high(o_fill_high),
		.o_addr_inc(o_addr_inc), .o_tdo(), .o_tdo_oe());
	jnp_chk jnp_chk_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_tck(port_if.tck), .i_tms(port_if.tms),
		.i_ext_reset_n(i_ext_reset_n), .i_core_reset(o_core_reset), .i_disable_bit(o_dis),
		.i_prog_mode(o_prog_mode), .i_cmd_exec(o_cmd_exec), .i_fill_write(o_fill_write), .i_addr_inc(o_addr_inc));
	// ----------------------------------------
	// Clock, monitors and helper tasks
	// ----------------------------------------
	// 20 MHz chip clock
	always #25 i_clk = ~i_clk;
	// Pulses are counted here so a scan never misses one while it waits
	always @(posedge i_clk) begin
		if (o_cmd_exec === 1'b1) n_exec++;
		if (o_addr_inc === 1'b1) n_inc++;
		if (o_fill_write === 1'b1) fill_q.push_back({o_fill_high, o_fill_data});
	end
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One scan through the programmer end; waits a bounded time for its done pulse
	task automatic scan(input logic ir, input logic [15:0] d, input logic [4:0] n, input logic idle);
		int k;
		@(negedge i_clk);
		i_is_ir = ir;
		i_data = d;
		i_len = n;
		i_end_idle = idle;
		i_start = 1'b1;
		@(negedge i_clk);
		i_start = 1'b0;
		chk("busy after start", {15'h0000, o_busy}, 16'h0001);
		k = 0;
		while (o_done !== 1'b1 && k < 2000) begin
			@(negedge i_clk);
			k++;
		end
		if (k >= 2000) n_fail++;
		rd = o_rdata;
		repeat (4) @(negedge i_clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Watchdog sized well above the whole sequence of scans
	initial begin
		repeat (40000) @(posedge i_clk);
		n_fail++;
		summarize();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(negedge i_clk);
		i_rstn = 1'b1;
		chk("core reset at release", {15'h0000, o_core_reset}, 16'h0001);
		chk("locked at power-on", {15'h0000, o_prog_mode}, 16'h0000);
		repeat (20) @(negedge i_clk);
		chk("core reset after time-out", {15'h0000, o_core_reset}, 16'h0000);
		// Reset hold goes first, before any unlock attempt
		scan(1'b1, 16'h000c, 5'd4, 1'b0);
		chk("instruction capture", rd, 16'h0001);
		scan(1'b0, 16'h0001, 5'd1, 1'b0);
		chk("reset hold", {15'h0000, o_core_reset}, 16'h0001);
		// A near-miss key must keep commands refused
		scan(1'b1, 16'h0004, 5'd4, 1'b0);
		scan(1'b0, 16'ha371, 5'd16, 1'b0);
		chk("mode after wrong key", {15'h0000, o_prog_mode}, 16'h0000);
		scan(1'b1, 16'h0005, 5'd4, 1'b0);
		scan(1'b0, 16'h2311, 5'd15, 1'b1);
		chk("command while locked", {1'b0, o_cmd}, 16'h0000);
		scan(1'b1, 16'h0004, 5'd4, 1'b0);
		scan(1'b0, jnp_pkg::UNLOCK_KEY, 5'd16, 1'b0);
		chk("mode after key", {15'h0000, o_prog_mode}, 16'h0001);
		// Command: previous result out, new command in, one execute on the idle clock after update
		i_cmd_result = 15'h5a4b;
		scan(1'b1, 16'h0005, 5'd4, 1'b0);
		e = n_exec;
		scan(1'b0, 16'h2311, 5'd15, 1'b1);
		chk("result shifted out", {1'b0, rd[14:0]}, 16'h5a4b);
		chk("command applied", {1'b0, o_cmd}, 16'h2311);
		chk("execute pulses", 16'(n_exec - e), 16'h0001);
		// Page fill: three bytes, low/high/low, one increment before the second low
		scan(1'b1, 16'h0006, 5'd4, 1'b0);
		fill_q.delete();
		e = n_inc;
		for (int i = 0; i < 3; i++) scan(1'b0, {8'h00, fb[i]}, 5'd8, 1'b1);
		// The last write needs further test clocks to land, so run one more scan
		scan(1'b1, 16'h0006, 5'd4, 1'b0);
		chk("fill writes", 16'(fill_q.size()), 16'h0003);
		for (int i = 0; i < 3; i++) chk("fill byte", {7'h00, fill_q[i]}, {7'h00, i[0], fb[i]});
		chk("fill increments", 16'(n_inc - e), 16'h0001);
		// Page fetch: low then high, increment only after the high byte
		i_mem_word = 16'hbe5a;
		scan(1'b1, 16'h0007, 5'd4, 1'b0);
		e = n_inc;
		scan(1'b0, 16'h0000, 5'd8, 1'b0);
		chk("fetch low", rd, 16'h005a);
		chk("no increment on low", 16'(n_inc - e), 16'h0000);
		scan(1'b0, 16'h0000, 5'd8, 1'b0);
		chk("fetch high", rd, 16'h00be);
		chk("increment on high", 16'(n_inc - e), 16'h0001);
		// Leaving programming by clearing the unlock register
		scan(1'b1, 16'h0004, 5'd4, 1'b0);
		scan(1'b0, 16'h0000, 5'd16, 1'b0);
		chk("mode after clear", {15'h0000, o_prog_mode}, 16'h0000);
		scan(1'b1, 16'h000c, 5'd4, 1'b0);
		scan(1'b0, 16'h0000, 5'd1, 1'b0);
		repeat (20) @(negedge i_clk);
		chk("release of hold", {15'h0000, o_core_reset}, 16'h0000);
		// Disable bit blocks the port until external reset clears it; the reset trick only serves programming here
		i_set_disable = 1'b1;
		@(negedge i_clk);
		i_set_disable = 1'b0;
		chk("disable bit set", {15'h0000, o_dis}, 16'h0001);
		scan(1'b1, 16'h000c, 5'd4, 1'b0);
		scan(1'b0, 16'h0001, 5'd1, 1'b0);
		repeat (20) @(negedge i_clk);
		chk("hold while disabled", {15'h0000, o_core_reset}, 16'h0000);
		i_ext_reset_n = 1'b0;
		repeat (6) @(negedge i_clk);
		chk("disable bit cleared", {15'h0000, o_dis}, 16'h0000);
		i_ext_reset_n = 1'b1;
		repeat (20) @(negedge i_clk);
		scan(1'b1, 16'h000c, 5'd4, 1'b0);
		scan(1'b0, 16'h0001, 5'd1, 1'b0);
		chk("hold after re-enable", {15'h0000, o_core_reset}, 16'h0001);
		scan(1'b0, 16'h0000, 5'd1, 1'b0);
		repeat (20) @(negedge i_clk);
		// Fuse off refuses the port outright
		i_fuse = 1'b0;
		scan(1'b1, 16'h000c, 5'd4, 1'b0);
		scan(1'b0, 16'h0001, 5'd1, 1'b0);
		repeat (20) @(negedge i_clk);
		chk("hold with fuse off", {15'h0000, o_core_reset}, 16'h0000);
		summarize();
	end
endmodule // tb_jtag_nvm_programming_port
`default_nettype wire
